// ### nandecc_acc.sv
// one parity accumulator for a single chip-select space
`timescale 1ns/100ps
`default_nettype none
`include "nandecc_map.svh"

module nandecc_acc (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // control
  input  wire logic                 clear,
  input  wire logic                 update,
  input  wire logic                 wide,
  input  wire logic [15:0]          data,
  // state
  output var  nandecc_pkg::nandecc_par_t parity_q,
  output var  nandecc_pkg::nandecc_cnt_t bytes_q,
  output var  logic                 overflow_q
);
  import nandecc_pkg::*;

  nandecc_par_t parity_d;
  logic [11:0]  addr;
  logic [8:0]   idx;
  logic         even_b;
  logic         odd_b;
  logic [3:0]   ncols;

  // ************************************************
  // bit address of the word: {word index, bit position}
  // ************************************************
  // RQ9 - 8-bit bit address
  // RQ10 - 16-bit bit address
  always_comb begin
    idx  = wide ? {1'b0, bytes_q[8:1]} : bytes_q[8:0];
    addr = wide ? {idx[7:0], 4'h0} : {idx, 3'h0};
    ncols = wide ? 4'(`NANDECC_COLS_16) : 4'(`NANDECC_COLS_8);
  end

  // ************************************************
  // next parity value
  // ************************************************
  // RQ14 - per-word parity update
  always_comb begin
    parity_d = parity_q;
    even_b   = 1'b0;
    odd_b    = 1'b0;
    for (int k = 0; k < `NANDECC_ORDERS; k++) begin
      even_b = 1'b0;
      odd_b  = 1'b0;
      if (k < int'(ncols)) begin
        // column parity: split the bits of the word by position bit k
        for (int p = 0; p < 16; p++) begin
          if (((p >> k) & 1) == 0) begin
            even_b = even_b ^ data[p];
          end else begin
            odd_b = odd_b ^ data[p];
          end
        end
      end else if (addr[k]) begin
        odd_b = ^data;
      end else begin
        even_b = ^data;
      end
      parity_d[`NANDECC_EVEN_POS(k)] = parity_q[`NANDECC_EVEN_POS(k)] ^ even_b;
      parity_d[`NANDECC_ODD_POS(k)]  = parity_q[`NANDECC_ODD_POS(k)] ^ odd_b;
    end
  end

  // ************************************************
  // parity register
  // ************************************************
  // RQ8 - start clears result
  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      parity_q <= `NANDECC_PAR_RST;
    end else if (update && (bytes_q < `NANDECC_MAX_BYTES)) begin
      // words past the block limit leave the parity alone
      parity_q <= parity_d;
    end
  end

  // ************************************************
  // byte count and overflow
  // ************************************************
  // RQ1 - block limited to 512 bytes
  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      bytes_q    <= `NANDECC_CNT_RST;
      overflow_q <= 1'b0;
    end else if (update) begin
      if (bytes_q >= `NANDECC_MAX_BYTES) begin
        overflow_q <= 1'b1;
      end else begin
        bytes_q <= bytes_q + (wide ? 10'h002 : 10'h001);
      end
    end
  end

endmodule
`default_nettype wire

// ### nandecc_gen.sv
// nand page ecc generator: start flags, space decode and four accumulators
//
// Operation
// RQ1 - nand-mode space computes ecc over up to 512 bytes
// RQ2 - accumulation starts only after the space start bit is written 1
// RQ3 - each space has its own accumulator and result
// RQ4 - software sets the start bit before the data transfers
// RQ5 - software reads the result only after the transfer finished
// RQ6 - software keeps a calculation within 512 bytes
// RQ7 - reading a space result clears that space start bit
// RQ8 - writing 1 to the start bit zeroes the result
// RQ9 - 8-bit flash: column orders 1,2,4, row orders 8..2048
// RQ10 - 16-bit flash: column orders 1..8, row orders 16..2048
// RQ11 - software ignores top row pairs for 256 or 128 byte blocks
// RQ12 - each space has a nand-mode bit enabling ecc
// RQ13 - software sets the space data width to the flash width
// RQ14 - each word updates parities, row side chosen by word index
// RQ15 - accumulator holds when idle and ignores non-nand spaces
`timescale 1ns/100ps
`default_nettype none
`include "nandecc_map.svh"

module nandecc_gen (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // configuration bits of the nand control register
  input  wire logic [3:0]                 space_nand_mode_bit,
  input  wire logic [3:0]                 space_data_width,
  // write-1 strobes of the space ecc start bits
  input  wire logic [3:0]                 space_ecc_start_bit,
  // read of a space ecc result register
  input  wire logic                       result_rd,
  input  wire logic [1:0]                 result_rd_space,
  // data transfers on the memory side
  input  wire nandecc_pkg::nandecc_xfer_s xfer,
  // status
  output var  logic [3:0]                 space_ecc_start_flag_q,
  output var  nandecc_pkg::nandecc_res_s  rd_result_q,
  output var  logic                       rd_valid_q
);
  import nandecc_pkg::*;

  logic [3:0]   start_d;
  logic [3:0]   rd_hit;
  logic [3:0]   upd;
  nandecc_par_t par      [4];
  nandecc_cnt_t cnt      [4];
  logic [3:0]   ovf;
  logic         xfer_par;

  // row parity of an 8-bit word covers the low byte only
  assign xfer_par = ^xfer.data[7:0];

  // ************************************************
  // decode of result reads and transfers
  // ************************************************
  always_comb begin
    rd_hit = 4'h0;
    upd    = 4'h0;
    for (int i = 0; i < `NANDECC_SPACES; i++) begin
      if (result_rd && (result_rd_space == 2'(i))) begin
        rd_hit[i] = 1'b1;
      end
      // RQ12 - nand mode gate
      // RQ15 - gate by mode and start
      if (xfer.valid && (xfer.space == 2'(i)) && space_nand_mode_bit[i] &&
          space_ecc_start_flag_q[i] && !space_ecc_start_bit[i]) begin
        upd[i] = 1'b1;
      end
    end
  end

  // ************************************************
  // start flags
  // ************************************************
  // RQ7 - read clears start, set wins
  always_comb begin
    start_d = space_ecc_start_flag_q;
    for (int i = 0; i < `NANDECC_SPACES; i++) begin
      if (space_ecc_start_bit[i]) begin
        start_d[i] = 1'b1;
      end else if (rd_hit[i]) begin
        start_d[i] = 1'b0;
      end
    end
  end

  // RQ2 - start bit arms accumulation
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      space_ecc_start_flag_q <= `NANDECC_FLAG_RST;
    end else begin
      space_ecc_start_flag_q <= start_d;
    end
  end

  // ************************************************
  // accumulators, one per space
  // ************************************************
  // RQ3 - independent per-space accumulators
  for (genvar g = 0; g < `NANDECC_SPACES; g++) begin : g_space
    nandecc_acc u_acc (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .clear      (space_ecc_start_bit[g]),
      .update     (upd[g]),
      .wide       (space_data_width[g]),
      .data       (space_data_width[g] ? xfer.data : {8'h00, xfer.data[7:0]}),
      .parity_q   (par[g]),
      .bytes_q    (cnt[g]),
      .overflow_q (ovf[g])
    );
  end

  // ************************************************
  // result read port
  // ************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_result_q <= '0;
      rd_valid_q  <= 1'b0;
    end else begin
      rd_valid_q <= result_rd;
      if (result_rd) begin
        rd_result_q.parity   <= par[result_rd_space];
        rd_result_q.bytes    <= cnt[result_rd_space];
        rd_result_q.overflow <= ovf[result_rd_space];
      end
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  for (genvar a = 0; a < `NANDECC_SPACES; a++) begin : g_chk
    logic col1_even;
    logic col8_even;
    assign col1_even = ^(xfer.data[7:0] & 8'h55);
    assign col8_even = ^xfer.data[7:0];

    sequence s_fresh_byte;
      (cnt[a] == '0) && !ovf[a] && upd[a] && !space_data_width[a];
    endsequence

    sequence s_fresh_word;
      (cnt[a] == '0) && !ovf[a] && upd[a] && space_data_width[a];
    endsequence

    AST_START_ARMS: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      space_ecc_start_bit[a] |=> space_ecc_start_flag_q[a] && (par[a] == '0))
      else $error("start write did not arm space");

    AST_NO_ARM_NO_UPDATE: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      !space_ecc_start_flag_q[a] && !space_ecc_start_bit[a] |=> $stable(par[a]))
      else $error("parity changed while not started");

    AST_CLEAR_ON_START: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
      space_ecc_start_bit[a] |=> (cnt[a] == '0) && !ovf[a])
      else $error("start write did not clear result");

    AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
      rd_hit[a] && !space_ecc_start_bit[a] |=> !space_ecc_start_flag_q[a])
      else $error("result read did not clear start");

    AST_OTHER_SPACE: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
      xfer.valid && (xfer.space != 2'(a)) && !space_ecc_start_bit[a] |=> $stable(par[a]))
      else $error("transfer to another space changed parity");

    AST_NOT_NAND: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
      !space_nand_mode_bit[a] && !space_ecc_start_bit[a] |=> $stable(cnt[a]))
      else $error("non nand space counted data");

    AST_HOLD_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // RQ15
      !upd[a] && !space_ecc_start_bit[a] |=> $stable(par[a]) && $stable(cnt[a]))
      else $error("accumulator moved while idle");

    AST_COL8_P1: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
      upd[a] && !space_data_width[a] && (cnt[a] < `NANDECC_MAX_BYTES) |=>
        par[a][0] == ($past(par[a][0]) ^ $past(col1_even)))
      else $error("8-bit order 1 even parity wrong");

    AST_ROW8_P8: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
      upd[a] && !space_data_width[a] && !cnt[a][0] && (cnt[a] < `NANDECC_MAX_BYTES) |=>
        par[a][6] == ($past(par[a][6]) ^ $past(xfer_par)) && $stable(par[a][7]))
      else $error("8-bit order 8 row parity wrong");

    AST_COL16_P8: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
      upd[a] && space_data_width[a] && (cnt[a] < `NANDECC_MAX_BYTES) |=>
        par[a][6] == ($past(par[a][6]) ^ $past(col8_even)))
      else $error("16-bit order 8 column parity wrong");

    AST_FIRST_BYTE: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
      s_fresh_byte |=> cnt[a] == 10'h001)
      else $error("first byte not counted once");

    AST_FIRST_WORD: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
      s_fresh_word |=> cnt[a] == 10'h002)
      else $error("first word not counted as two bytes");

    AST_BLOCK_LIMIT: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
      cnt[a] <= `NANDECC_MAX_BYTES)
      else $error("byte count beyond block size");
  end

  AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
    result_rd |=> rd_valid_q)
    else $error("result read gave no data");

endmodule
`default_nettype wire

// ### nandecc_map.svh
// constants for the per-space nand page ecc generator
`ifndef NANDECC_MAP_SVH
`define NANDECC_MAP_SVH

// number of chip-select spaces, each with its own accumulator
`define NANDECC_SPACES     4
// largest block that one calculation covers, in bytes
`define NANDECC_MAX_BYTES  10'h200
// parity orders 1 .. 2048, one even and one odd bit each
`define NANDECC_ORDERS     12
`define NANDECC_PAR_W      24
// column parity orders for 8-bit and 16-bit flash
`define NANDECC_COLS_8     3
`define NANDECC_COLS_16    4
// result field layout: bit 2k even, bit 2k+1 odd parity of order 2**k
`define NANDECC_EVEN_POS(k) (2*(k))
`define NANDECC_ODD_POS(k)  (2*(k)+1)
// reset values
`define NANDECC_PAR_RST    24'h00_0000
`define NANDECC_CNT_RST    10'h000
`define NANDECC_FLAG_RST   4'h0

`endif

// ### nandecc_pkg.sv
// types shared by the nand page ecc generator
`default_nettype none
package nandecc_pkg;

  typedef logic [23:0] nandecc_par_t;
  typedef logic [9:0]  nandecc_cnt_t;

  // one data transfer on the memory side
  typedef struct packed {
    logic        valid;
    logic [1:0]  space;
    logic [15:0] data;
  } nandecc_xfer_s;

  // result of one space as software sees it
  typedef struct packed {
    nandecc_par_t parity;
    nandecc_cnt_t bytes;
    logic         overflow;
  } nandecc_res_s;

endpackage
`default_nettype wire

// ### npeg_flash.sv
// behavioural nand flash that streams a page onto the transfer bus
`timescale 1ns/100ps
`default_nettype none

module npeg_flash (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // request from the bench
  input  wire logic                       go,
  input  wire logic [1:0]                 space,
  input  wire logic [9:0]                 nwords,
  input  wire logic [511:0][15:0]         page,
  // memory side
  output var  nandecc_pkg::nandecc_xfer_s xfer,
  output var  logic                       busy
);
  import nandecc_pkg::*;
  logic [9:0] idx_q;
  logic [9:0] left_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idx_q  <= 10'h000;
      left_q <= 10'h000;
      xfer   <= '0;
    end else if (go) begin
      idx_q      <= 10'h000;
      left_q     <= nwords;
      xfer.valid <= 1'b0;
      xfer.space <= space;
    end else if (left_q != 10'h000) begin
      xfer.valid <= 1'b1;
      xfer.data  <= page[idx_q[8:0]];
      idx_q      <= idx_q + 10'h001;
      left_q     <= left_q - 10'h001;
    end else begin
      // released bus inverts every cycle, alternating the inverse of the last word and the word itself
      xfer.valid <= 1'b0;
      xfer.data  <= ~xfer.data;
    end
  end
  assign busy = go | (left_q != 10'h000) | xfer.valid;
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the nand page ecc generator
`timescale 1ns/100ps
`default_nettype none

module tb;
  import nandecc_pkg::*;
  logic               ref_clk, rst, result_rd, rd_valid_q, go, busy, w;
  logic [3:0]         mode, width, start_bit, flag_q;
  logic [1:0]         rd_space, fsp, s;
  logic [9:0]         fnw;
  logic [511:0][15:0] page;
  nandecc_xfer_s      xfer;
  nandecc_res_s       res_q, r;
  int                 n_mismatch, check_count, n;

  nandecc_gen DUT (.ref_clk(ref_clk), .rst(rst), .space_nand_mode_bit(mode),
    .space_data_width(width), .space_ecc_start_bit(start_bit), .result_rd(result_rd),
    .result_rd_space(rd_space), .xfer(xfer), .space_ecc_start_flag_q(flag_q),
    .rd_result_q(res_q), .rd_valid_q(rd_valid_q));
  npeg_flash flash (.ref_clk(ref_clk), .rst(rst), .go(go), .space(fsp), .nwords(fnw),
    .page(page), .xfer(xfer), .busy(busy));

  // ****************
  // helpers
  // ****************
  function automatic nandecc_res_s expect_res(input int nw, input logic wd);
    nandecc_res_s e;
    int bw;
    int addr;
    e = '0;
    bw = wd ? 16 : 8;
    // top pairs of short blocks are still produced
    for (int m = 0; m < nw; m++) begin
      if (e.bytes == 10'h200) e.overflow = 1'b1;
      else begin
        e.bytes = e.bytes + 10'(bw / 8);
        for (int b = 0; b < bw; b++) begin
          addr = m * bw + b;
          for (int k = 0; k < 12; k++) e.parity[2 * k + addr[k]] ^= page[m][b];
        end
      end
    end
    return e;
  endfunction

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic start(input logic [1:0] sp);
    @(posedge ref_clk);
    start_bit <= 4'h1 << sp;
    @(posedge ref_clk);
    start_bit <= 4'h0;
    #1;
    check(35'(flag_q[sp]), 35'h1);
  endtask

  task automatic stream(input logic [1:0] sp, input int nw);
    int t;
    @(posedge ref_clk);
    go  <= 1'b1;
    fsp <= sp;
    fnw <= 10'(nw);
    @(posedge ref_clk);
    go <= 1'b0;
    t = 0;
    #1;
    while (busy === 1'b1 && t < 1000) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    if (t >= 1000) begin
      n_mismatch++;
      $display("Error at %0t: page stream did not finish", $time);
    end
  endtask

  task automatic rd(input logic [1:0] sp, output nandecc_res_s res);
    @(posedge ref_clk);
    result_rd <= 1'b1;
    rd_space  <= sp;
    @(posedge ref_clk);
    result_rd <= 1'b0;
    #1;
    check(35'(rd_valid_q), 35'h1);
    res = res_q;
    check(35'(flag_q[sp]), 35'h0);
  endtask

  // ****************
  // stimulus
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    mode = 4'hf;
    width = 4'h0;
    start_bit = 4'h0;
    result_rd = 1'b0;
    rd_space = 2'h0;
    go = 1'b0;
    fsp = 2'h0;
    fnw = 10'h000;
    page = '0;
    void'($urandom(3));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check(35'({rd_valid_q, flag_q}), 35'h0);
    stream(2'd0, 5);
    rd(2'd0, r);
    check(r, '0);
    for (int i = 0; i < 6; i++) begin
      s = 2'($urandom);
      w = 1'($urandom);
      n = (i == 0) ? (w ? 256 : 512) : 1 + $urandom % (w ? 256 : 512);
      @(posedge ref_clk);
      foreach (page[j]) page[j] <= 16'($urandom);
      width[s] <= w;
      start(s);
      start(s ^ 2'd1);
      stream(s, n);
      rd(s, r);
      if (w) check(r, expect_res(n, w));
      else check(r, expect_res(n, w));
      rd(s ^ 2'd1, r);
      check(r, '0);
      stream(s, 3);
      rd(s, r);
      check(r, expect_res(n, w));
      start(s);
      rd(s, r);
      check(r, '0);
    end
    @(posedge ref_clk);
    mode[2] <= 1'b0;
    start(2'd2);
    stream(2'd2, 9);
    rd(2'd2, r);
    check(r, '0);
    @(posedge ref_clk);
    mode[2] <= 1'b1;
    width[3] <= 1'b1;
    start(2'd3);
    stream(2'd3, 258);
    rd(2'd3, r);
    check(r, expect_res(258, 1'b1));
    stream(2'd1, 4);
    rd(2'd1, r);
    conclude();
  end
endmodule
`default_nettype wire
